// ### core/pla_pkg.sv
// shared constants, types and register map of the programmable macrocell array
package pla_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int NUM_CELLS      = 8;
  localparam int TERMS_PER_CELL = 8;
  localparam int NUM_TERMS      = NUM_CELLS * TERMS_PER_CELL;
  localparam int ARRAY_SIGNALS  = 16;
  localparam int LIT_W          = 2 * ARRAY_SIGNALS;
  localparam int SIG_W          = 64;
  localparam int ADDR_W         = 9;
  localparam int DATA_W         = 32;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] FUSE_BASE_ADDR  = 9'h000;
  localparam logic [ADDR_W-1:0] CFG_ADDR        = 9'h100;
  localparam logic [ADDR_W-1:0] TERMDIS_LO_ADDR = 9'h104;
  localparam logic [ADDR_W-1:0] TERMDIS_HI_ADDR = 9'h108;
  localparam logic [ADDR_W-1:0] SECURITY_ADDR   = 9'h10C;
  localparam logic [ADDR_W-1:0] SIG_LO_ADDR     = 9'h110;
  localparam logic [ADDR_W-1:0] SIG_HI_ADDR     = 9'h114;
  localparam logic [ADDR_W-1:0] CTRL_ADDR       = 9'h118;
  localparam logic [ADDR_W-1:0] STATUS_ADDR     = 9'h11C;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CFG_NOREG_BIT    = 0;
  localparam int CFG_EMUL_BIT     = 1;
  localparam int CFG_CELL_LSB     = 8;
  localparam int CFG_POL_LSB      = 16;
  localparam int SECURITY_BIT     = 0;
  localparam int CTRL_PROG_BIT    = 0;
  localparam int CTRL_ERASE_BIT   = 1;
  localparam int CTRL_PRELOAD_BIT = 2;
  localparam int STAT_FF_LSB      = 0;
  localparam int STAT_STANDBY_BIT = 8;
  localparam int STAT_SECURE_BIT  = 9;
  localparam int STAT_PROG_BIT    = 10;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [SIG_W-1:0]  SIG_RESET    = 64'h0;
  localparam logic [DATA_W-1:0] FUSE_RESET   = 32'h0;
  localparam int STANDBY_IDLE_NS = 50;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int STANDBY_CYC_RAW = (STANDBY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STANDBY_CYCLES  = (STANDBY_CYC_RAW < 1) ? 1 : STANDBY_CYC_RAW;
  localparam logic [7:0] STANDBY_COUNT = 8'(STANDBY_CYCLES);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [NUM_CELLS-1:0] cell_polarity_local;
    logic [NUM_CELLS-1:0] cell_config_local;
    logic                 family_emulation_global;
    logic                 registers_disallowed_global;
  } config_type;

  typedef struct packed {
    logic [NUM_CELLS-1:0] io;
    logic                 oe_n;
    logic                 clk;
    logic [NUM_CELLS-1:0] inputs;
  } pin_sample_type;

  typedef enum logic [1:0] {
    MODE_REGISTERED,
    MODE_COMB_IO,
    MODE_COMB_OUT,
    MODE_INPUT
  } cell_mode_type;

endpackage : pla_pkg

// ### core/product_term_array.sv
// wide AND plane: one product term per fuse row, with per-term disable
`timescale 1ns/1ns
module product_term_array
  import pla_pkg::*;
#(
  parameter int TERMS = NUM_TERMS,
  parameter int WIDTH = LIT_W
) (
  input  wire logic [WIDTH-1:0]            literals, // true/complement signal pairs
  input  wire logic [TERMS-1:0][WIDTH-1:0] masks,    // 1 = literal connected
  input  wire logic [TERMS-1:0]            term_on,  // 0 = term powered down
  output logic      [TERMS-1:0]            terms     // product term values
);

  // an empty mask gives high; a true/complement pair in one mask gives low
  for (genvar t = 0; t < TERMS; t++) begin : g_term
    assign terms[t] = term_on[t] & (&(literals | ~masks[t]));
  end

endmodule : product_term_array

// ### core/macrocell.sv
// one output macrocell: mode decode, OR gate, polarity, output and feedback select
`timescale 1ns/1ns
module macrocell
  import pla_pkg::*;
#(
  parameter bit IS_END = 1'b0
) (
  input  wire logic                      no_registers, // registers_disallowed_global
  input  wire logic                      emulation,    // family_emulation_global
  input  wire logic                      cell_cfg,     // cell_config_local
  input  wire logic                      polarity,     // cell_polarity_local
  input  wire logic [TERMS_PER_CELL-1:0] terms,        // this cell's product terms
  input  wire logic                      ff_q,         // cell flip-flop
  input  wire logic                      own_pin,      // sampled own io pin
  input  wire logic                      alt_pin,      // neighbour pin or end pin
  input  wire logic                      oe_n,         // sampled shared enable pin
  output logic                           pin_val,      // value for the io pin
  output logic                           pin_en,       // io pin driver enable
  output logic                           feedback,     // signal into the AND plane
  output logic                           ff_next,      // flip-flop data input
  output cell_mode_type                  mode          // decoded cell mode
);

  logic sum;
  logic data;

  always_comb begin
    case ({no_registers, emulation, cell_cfg})
      3'h2:        mode = MODE_REGISTERED;
      3'h3, 3'h7:  mode = MODE_COMB_IO;
      3'h5:        mode = MODE_INPUT;
      default:     mode = MODE_COMB_OUT;
    endcase
  end

  always_comb begin
    // the last term steers the driver in the I/O modes
    if (mode == MODE_COMB_IO) begin
      sum = |terms[TERMS_PER_CELL-2:0];
    end else begin
      sum = |terms;
    end
    data    = polarity ? sum : ~sum;
    ff_next = ~data;
    case (mode)
      MODE_REGISTERED: begin
        pin_val = ~ff_q;
        pin_en  = ~oe_n;
      end
      MODE_COMB_IO: begin
        pin_val = data;
        pin_en  = terms[TERMS_PER_CELL-1];
      end
      MODE_INPUT: begin
        pin_val = data;
        pin_en  = 1'b0;
      end
      default: begin
        pin_val = data;
        pin_en  = 1'b1;
      end
    endcase
    if ((IS_END && no_registers) || mode == MODE_INPUT) begin
      feedback = alt_pin;
    end else if (mode == MODE_REGISTERED) begin
      feedback = ~ff_q;
    end else begin
      feedback = own_pin;
    end
  end

endmodule : macrocell

// ### core/pla_top.sv
// programmable macrocell array with pin sampling, standby and Avalon-MM programming port
//
// Function
// - input mode disables the output buffer
// - input mode feeds back neighbour or end pin
// - three config bits decode the cell mode
// - polarity bit XORs the sum output
// - all flip-flops clear at power-up
// - registered outputs show high after power-up
// - combinatorial outputs show their equation value
// - registers preload from the io pins
// - security blocks readback of the pattern
// - security clears only with whole-array erase
// - 64-bit user signature store
// - signature readable whatever the security bit
// - idle inputs put the device into standby
// - outputs hold their level in standby
// - any input change leaves standby at once
// - disabled product terms contribute nothing when ZERO_POWER is set
// - registers load on clock pin rising edge
// - I/O modes use seven terms plus enable
// - empty term high, conflicting term low
`timescale 1ns/1ns
module pla_top
  import pla_pkg::*;
#(
  parameter bit ZERO_POWER = 1'b1
) (
  input  wire logic                 sys_clk,         // system clock, 10 MHz
  input  wire logic                 resetn,          // async reset, active low
  input  wire logic                 ce,              // clock enable, freezes all state
  input  wire logic [NUM_CELLS-1:0] in_pin,          // dedicated array inputs
  input  wire logic                 clk_pin,         // register clock pin
  input  wire logic                 oe_n_pin,        // shared output enable pin
  input  wire logic [NUM_CELLS-1:0] io_in,           // io pin levels
  output logic      [NUM_CELLS-1:0] io_out,          // io pin drive values
  output logic      [NUM_CELLS-1:0] io_oe,           // io pin drive enables
  input  wire logic [ADDR_W-1:0]    av_address,      // byte address
  input  wire logic                 av_read,         // read request
  input  wire logic                 av_write,        // write request
  input  wire logic [DATA_W-1:0]    av_writedata,    // write data
  output logic      [DATA_W-1:0]    av_readdata,     // read data
  output logic                      av_waitrequest   // high until answered
);

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  pin_sample_type raw;
  pin_sample_type s1_q, s1_d;
  pin_sample_type s2_q, s2_d;
  pin_sample_type prev_q, prev_d;
  logic           in_changed;
  logic           clk_rise;

  assign raw = '{io: io_in, oe_n: oe_n_pin, clk: clk_pin, inputs: in_pin};

  always_comb begin
    s1_d   = raw;
    s2_d   = s1_q;
    prev_d = s2_q;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      prev_q <= '0;
    end else if (ce) begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      prev_q <= prev_d;
    end
  end

  assign in_changed = (s2_q != prev_q);
  assign clk_rise   = s2_q.clk & ~prev_q.clk;

  // ****************************************************************
  // logic array and macrocells
  // ****************************************************************
  logic [NUM_TERMS-1:0][LIT_W-1:0] fuse_q, fuse_d;
  logic [NUM_TERMS-1:0]            term_dis_q, term_dis_d;
  logic [NUM_TERMS-1:0]            term_on;
  logic [NUM_TERMS-1:0]            term_val;
  logic [ARRAY_SIGNALS-1:0]        sig;
  logic [LIT_W-1:0]                lit;
  config_type                      cfg_q, cfg_d;
  logic [NUM_CELLS-1:0]            ff_q, ff_d;
  logic [NUM_CELLS-1:0]            ff_next;
  logic [NUM_CELLS-1:0]            pin_val;
  logic [NUM_CELLS-1:0]            pin_en;
  logic [NUM_CELLS-1:0]            fb;
  cell_mode_type                   mode [NUM_CELLS];

  assign sig     = {fb, s2_q.inputs};
  assign term_on = ZERO_POWER ? ~term_dis_q : {NUM_TERMS{1'b1}};

  for (genvar k = 0; k < ARRAY_SIGNALS; k++) begin : g_lit
    assign lit[2*k]   = sig[k];
    assign lit[2*k+1] = ~sig[k];
  end

  product_term_array #(
    .TERMS (NUM_TERMS),
    .WIDTH (LIT_W)
  ) u_array (
    .literals (lit),
    .masks    (fuse_q),
    .term_on  (term_on),
    .terms    (term_val)
  );

  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    logic alt;
    // end cells take the shared enable and clock pins instead of a neighbour
    if (i == 0) begin : g_first
      assign alt = s2_q.oe_n;
    end else if (i == NUM_CELLS - 1) begin : g_last
      assign alt = s2_q.clk;
    end else begin : g_mid
      assign alt = s2_q.io[i+1];
    end
    macrocell #(
      .IS_END (i == 0 || i == NUM_CELLS - 1)
    ) u_cell (
      .no_registers (cfg_q.registers_disallowed_global),
      .emulation    (cfg_q.family_emulation_global),
      .cell_cfg     (cfg_q.cell_config_local[i]),
      .polarity     (cfg_q.cell_polarity_local[i]),
      .terms        (term_val[i*TERMS_PER_CELL +: TERMS_PER_CELL]),
      .ff_q         (ff_q[i]),
      .own_pin      (s2_q.io[i]),
      .alt_pin      (alt),
      .oe_n         (s2_q.oe_n),
      .pin_val      (pin_val[i]),
      .pin_en       (pin_en[i]),
      .feedback     (fb[i]),
      .ff_next      (ff_next[i]),
      .mode         (mode[i])
    );
  end

  // ****************************************************************
  // bus, programming state, registers and standby
  // ****************************************************************
  logic                 sec_q, sec_d;
  logic [SIG_W-1:0]     sig_store_q, sig_store_d;
  logic                 prog_q, prog_d;
  logic                 wait_q, wait_d;
  logic [DATA_W-1:0]    rdata_q, rdata_d;
  logic [DATA_W-1:0]    rd_val;
  logic [NUM_CELLS-1:0] out_q, out_d;
  logic [NUM_CELLS-1:0] oe_q, oe_d;
  logic [7:0]           idle_q, idle_d;
  logic                 stby_q, stby_d;
  logic                 wr_take;
  logic                 wake;
  logic                 upd;
  logic                 preload_hit;
  logic                 erase_hit;
  logic                 fuse_hit;

  assign wr_take     = av_write & ~wait_q;
  assign fuse_hit    = (av_address < CFG_ADDR);
  assign preload_hit = wr_take && av_address == CTRL_ADDR && av_writedata[CTRL_PRELOAD_BIT];
  assign erase_hit   = wr_take && prog_q && av_address == CTRL_ADDR
                       && av_writedata[CTRL_ERASE_BIT];
  // bus writes count as activity so a preload is never hidden by standby
  assign wake        = in_changed | wr_take;
  assign upd         = ~stby_q | wake;

  always_comb begin
    rd_val = '0;
    if (fuse_hit) begin
      if (!sec_q) begin
        rd_val = fuse_q[av_address[7:2]];
      end
    end else begin
      case (av_address)
        CFG_ADDR: begin
          if (!sec_q) begin
            rd_val[CFG_NOREG_BIT]               = cfg_q.registers_disallowed_global;
            rd_val[CFG_EMUL_BIT]                = cfg_q.family_emulation_global;
            rd_val[CFG_CELL_LSB +: NUM_CELLS]   = cfg_q.cell_config_local;
            rd_val[CFG_POL_LSB +: NUM_CELLS]    = cfg_q.cell_polarity_local;
          end
        end
        TERMDIS_LO_ADDR: rd_val = sec_q ? '0 : term_dis_q[DATA_W-1:0];
        TERMDIS_HI_ADDR: rd_val = sec_q ? '0 : term_dis_q[NUM_TERMS-1:DATA_W];
        SECURITY_ADDR:   rd_val[SECURITY_BIT] = sec_q;
        SIG_LO_ADDR:     rd_val = sig_store_q[DATA_W-1:0];
        SIG_HI_ADDR:     rd_val = sig_store_q[SIG_W-1:DATA_W];
        CTRL_ADDR:       rd_val[CTRL_PROG_BIT] = prog_q;
        STATUS_ADDR: begin
          rd_val[STAT_FF_LSB +: NUM_CELLS] = ff_q;
          rd_val[STAT_STANDBY_BIT]         = stby_q;
          rd_val[STAT_SECURE_BIT]          = sec_q;
          rd_val[STAT_PROG_BIT]            = prog_q;
        end
        default:         rd_val = '0;
      endcase
    end
  end

  always_comb begin
    fuse_d      = fuse_q;
    term_dis_d  = term_dis_q;
    cfg_d       = cfg_q;
    sec_d       = sec_q;
    sig_store_d = sig_store_q;
    prog_d      = prog_q;
    wait_d      = 1'b1;
    rdata_d     = rdata_q;
    ff_d        = ff_q;
    out_d       = out_q;
    oe_d        = oe_q;
    // one wait cycle, then waitrequest is low for one cycle only, whatever the master does
    if ((av_read || av_write) && wait_q) begin
      wait_d = 1'b0;
      if (av_read) begin
        rdata_d = rd_val;
      end
    end
    if (preload_hit) begin
      ff_d = ~s2_q.io;
    end else if (clk_rise) begin
      ff_d = ff_next;
    end
    if (wr_take && av_address == CTRL_ADDR) begin
      prog_d = av_writedata[CTRL_PROG_BIT];
    end
    if (wr_take && prog_q) begin
      if (fuse_hit) begin
        fuse_d[av_address[7:2]] = av_writedata;
      end else begin
        case (av_address)
          CFG_ADDR: begin
            cfg_d.registers_disallowed_global = av_writedata[CFG_NOREG_BIT];
            cfg_d.family_emulation_global     = av_writedata[CFG_EMUL_BIT];
            cfg_d.cell_config_local  = av_writedata[CFG_CELL_LSB +: NUM_CELLS];
            cfg_d.cell_polarity_local = av_writedata[CFG_POL_LSB +: NUM_CELLS];
          end
          TERMDIS_LO_ADDR: term_dis_d[DATA_W-1:0]         = av_writedata;
          TERMDIS_HI_ADDR: term_dis_d[NUM_TERMS-1:DATA_W] = av_writedata;
          SECURITY_ADDR:   sec_d = sec_q | av_writedata[SECURITY_BIT];
          SIG_LO_ADDR:     sig_store_d[DATA_W-1:0]     = av_writedata;
          SIG_HI_ADDR:     sig_store_d[SIG_W-1:DATA_W] = av_writedata;
          default:         sec_d = sec_q;
        endcase
      end
    end
    if (erase_hit) begin
      fuse_d     = '0;
      cfg_d      = '0;
      term_dis_d = '0;
      sec_d      = 1'b0;
    end
    idle_d = wake ? 8'h00 : ((idle_q == 8'hFF) ? idle_q : idle_q + 8'h01);
    stby_d = ZERO_POWER && (idle_d >= STANDBY_COUNT);
    if (upd) begin
      out_d = pin_val;
      oe_d  = pin_en;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fuse_q      <= '0;
      term_dis_q  <= '0;
      cfg_q       <= '0;
      sec_q       <= 1'b0;
      sig_store_q <= SIG_RESET;
      prog_q      <= 1'b0;
      wait_q      <= 1'b1;
      rdata_q     <= '0;
      ff_q        <= '0;
      out_q       <= '0;
      oe_q        <= '0;
      idle_q      <= 8'h00;
      stby_q      <= 1'b0;
    end else if (ce) begin
      fuse_q      <= fuse_d;
      term_dis_q  <= term_dis_d;
      cfg_q       <= cfg_d;
      sec_q       <= sec_d;
      sig_store_q <= sig_store_d;
      prog_q      <= prog_d;
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
      ff_q        <= ff_d;
      out_q       <= out_d;
      oe_q        <= oe_d;
      idle_q      <= idle_d;
      stby_q      <= stby_d;
    end
  end

  assign io_out         = out_q;
  assign io_oe          = oe_q;
  assign av_readdata    = rdata_q;
  assign av_waitrequest = wait_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence erase_taken;
    ce && erase_hit;
  endsequence

  sequence sig_lo_read;
    ce && av_read && wait_q && av_address == SIG_LO_ADDR;
  endsequence

  chk_input_buffer_off: assert property (
    (ce && upd && mode[4] == MODE_INPUT) |=> !io_oe[4])
    else $error("input mode cell drives its pin");
  chk_input_feedback: assert property (
    (mode[5] == MODE_INPUT) |-> fb[5] == s2_q.io[6])
    else $error("input mode feedback not from neighbour");
  chk_mode_decode: assert property (
    (!cfg_q.registers_disallowed_global && cfg_q.family_emulation_global
     && !cfg_q.cell_config_local[3]) |-> mode[3] == MODE_REGISTERED)
    else $error("registered mode not decoded");
  chk_polarity_high: assert property (
    (ce && upd && mode[1] == MODE_COMB_OUT && cfg_q.cell_polarity_local[1])
    |=> io_out[1] == $past(|term_val[15:8]))
    else $error("active high output wrong");
  chk_reg_out_high: assert property (
    (ce && upd && mode[4] == MODE_REGISTERED && !ff_q[4]) |=> io_out[4])
    else $error("cleared register not shown high");
  chk_preload_pins: assert property (
    (ce && preload_hit) |=> ff_q == ~$past(s2_q.io))
    else $error("preload did not take pin levels");
  chk_secure_readback: assert property (
    (ce && av_read && wait_q && sec_q && fuse_hit) |=> av_readdata == 32'h0)
    else $error("secured pattern was read back");
  chk_secure_hold: assert property (
    (ce && sec_q && !erase_hit) |=> sec_q)
    else $error("security cleared without erase");
  chk_erase_clears: assert property (
    erase_taken |=> !sec_q && fuse_q == '0)
    else $error("erase left security or array");
  chk_signature_read: assert property (
    sig_lo_read |=> !av_waitrequest && av_readdata == $past(sig_store_q[31:0]))
    else $error("signature not readable");
  chk_standby_hold: assert property (
    (ce && stby_q && !wake) |=> $stable(io_out) && $stable(io_oe))
    else $error("outputs moved in standby");
  chk_wake_now: assert property (
    (ce && in_changed) |=> !stby_q && io_out == $past(pin_val))
    else $error("input change did not leave standby");
  chk_term_disabled: assert property (
    (ZERO_POWER && term_dis_q[5]) |-> !term_val[5])
    else $error("disabled term contributes");
  chk_clock_capture: assert property (
    (ce && clk_rise && !preload_hit) |=> ff_q == $past(ff_next))
    else $error("register missed clock edge");
  chk_io_enable_term: assert property (
    (ce && upd && mode[1] == MODE_COMB_IO) |=> io_oe[1] == $past(term_val[15]))
    else $error("io enable not from eighth term");
  chk_cfg_locked: assert property (
    (ce && !prog_q) |=> $stable(cfg_q) && $stable(fuse_q))
    else $error("configuration changed outside programming");

endmodule : pla_top

// ### verification/board_model.sv
// board model: resolves the io wires and drives them where the array does not
`timescale 1ns/1ns
module board_model
  import pla_pkg::*;
(
  input  wire logic                 sys_clk, // system clock
  input  wire logic [NUM_CELLS-1:0] io_out,  // array drive values
  input  wire logic [NUM_CELLS-1:0] io_oe,   // array drive enables
  input  wire logic [NUM_CELLS-1:0] brd_val, // board drive values
  input  wire logic [NUM_CELLS-1:0] brd_en,  // board drive enables
  output logic      [NUM_CELLS-1:0] io_in    // resolved wire levels
);
  // undriven lines toggle every cycle so no stale level can pass
  logic [NUM_CELLS-1:0] float_q = 8'h55;

  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      io_in[i] = io_oe[i] ? io_out[i] : (brd_en[i] ? brd_val[i] : float_q[i]);
    end
  end
endmodule : board_model

// ### verification/tb_top.sv
// self-checking bench for the macrocell array
`timescale 1ns/1ns
module tb_top
  import pla_pkg::*;
;
  logic              sys_clk = 0;
  logic              resetn = 0;
  logic              clk_pin = 0;
  logic              oe_n_pin = 1;
  logic [7:0]        in_pin = 0;
  logic [7:0]        brd_val = 0;
  logic [7:0]        brd_en = 0;
  logic [7:0]        io_out;
  logic [7:0]        io_oe;
  logic [7:0]        io_in;
  logic [ADDR_W-1:0] av_address = 0;
  logic              av_read = 0;
  logic              av_write = 0;
  logic              av_waitrequest;
  logic [DATA_W-1:0] av_writedata = 0;
  logic [DATA_W-1:0] av_readdata;
  logic [DATA_W-1:0] rd;
  int                err_count = 0;
  int                num_checks = 0;

  always #50 sys_clk = ~sys_clk;

  pla_top pla_top_inst (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .in_pin(in_pin),
    .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .av_address(av_address), .av_read(av_read), .av_write(av_write),
    .av_writedata(av_writedata), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest));

  board_model board_model_inst (.sys_clk(sys_clk), .io_out(io_out), .io_oe(io_oe),
    .brd_val(brd_val), .brd_en(brd_en), .io_in(io_in));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_bus({24'h0, got}, {24'h0, exp});
  endtask : chk_pin

  // request held until waitrequest is sampled low; a hang ends the run
  task automatic bus(input bit wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    av_address <= a;
    av_writedata <= d;
    av_write <= wr;
    av_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (av_waitrequest === 1'b0) break;
    end
    rd = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    if (n == 20) begin
      err_count++;
      give_verdict();
    end
  endtask : bus

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_bus(rd & m, e);
  endtask : rdchk

  // pins reach io_out three edges after they change
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  initial begin
    repeat (20) @(posedge sys_clk);
    chk_pin(io_oe, 8'h00);
    chk_bus({31'h0, av_waitrequest}, 32'h1);
    resetn <= 1'b1;
    rdchk(STATUS_ADDR, 32'hFFFFFEFF, 32'h0);
    wr(CFG_ADDR, 32'h1);
    rdchk(CFG_ADDR, 32'hFFFFFFFF, 32'h0);
    rdchk(9'h120, 32'hFFFFFFFF, 32'h0);
    wr(CTRL_ADDR, 32'h1);
    wr(FUSE_BASE_ADDR, 32'h3);
    wr(SIG_LO_ADDR, 32'h89ABCDEF);
    wr(SIG_HI_ADDR, 32'h01234567);
    wr(SECURITY_ADDR, 32'h1);
    rdchk(FUSE_BASE_ADDR, 32'hFFFFFFFF, 32'h0);
    rdchk(SIG_HI_ADDR, 32'hFFFFFFFF, 32'h01234567);
    rdchk(STATUS_ADDR, 32'h200, 32'h200);
    wr(CTRL_ADDR, 32'h3);
    rdchk(STATUS_ADDR, 32'h200, 32'h0);
    rdchk(SIG_LO_ADDR, 32'hFFFFFFFF, 32'h89ABCDEF);
    $display("test registers done");
    wr(CFG_ADDR, 32'h00FF0001);
    wr(CTRL_ADDR, 32'h0);
    settle();
    chk_pin(io_oe, 8'hFF);
    chk_pin(io_out, 8'hFF);
    wr(CTRL_ADDR, 32'h1);
    wr(CFG_ADDR, 32'h000F0001);
    wr(FUSE_BASE_ADDR, 32'h3);
    wr(TERMDIS_LO_ADDR, 32'hFE);
    wr(CTRL_ADDR, 32'h0);
    settle();
    chk_pin(io_out, 8'h0E);
    wr(CTRL_ADDR, 32'h1);
    wr(CFG_ADDR, 32'h000FF001);
    wr(CTRL_ADDR, 32'h0);
    settle();
    chk_pin(io_oe, 8'h0F);
    wr(CTRL_ADDR, 32'h1);
    wr(CFG_ADDR, 32'h00FFFF03);
    wr(TERMDIS_LO_ADDR, 32'h0000807F);
    wr(CTRL_ADDR, 32'h0);
    settle();
    chk_pin(io_oe, 8'hFD);
    chk_pin(io_out, 8'hFE);
    $display("test combinatorial done");
    wr(CTRL_ADDR, 32'h3);
    wr(CFG_ADDR, 32'h00000002);
    wr(CTRL_ADDR, 32'h0);
    @(posedge sys_clk);
    oe_n_pin <= 1'b0;
    settle();
    chk_pin(io_out, 8'hFF);
    chk_pin(io_oe, 8'hFF);
    @(posedge sys_clk);
    clk_pin <= 1'b1;
    settle();
    chk_pin(io_out, 8'h00);
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_pin(io_out, 8'h00);
    rdchk(STATUS_ADDR, 32'h100, 32'h100);
    @(posedge sys_clk);
    oe_n_pin <= 1'b1;
    brd_val <= 8'hA5;
    brd_en <= 8'hFF;
    settle();
    chk_pin(io_oe, 8'h00);
    wr(CTRL_ADDR, 32'h4);
    rdchk(STATUS_ADDR, 32'hFF, 32'h5A);
    @(posedge sys_clk);
    oe_n_pin <= 1'b0;
    brd_en <= 8'h00;
    settle();
    chk_pin(io_out, 8'hA5);
    $display("test registered done");
    give_verdict();
  end
endmodule : tb_top
